/* File: design/osc_mode_consts.vh */
// Constants for the oscillator mode selection block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef OSC_MODE_CONSTS_VH
`define OSC_MODE_CONSTS_VH

// ==========================================================
// Mode field
`define OSC_MODE_WIDTH        4
`define OSC_MODE_COUNT        10
`define OSC_CODE_PLL_CRYSTAL  4'h6
// Default codes of the other nine modes (decoder parameters)
`define OSC_CODE_LOW_POWER    4'h0
`define OSC_CODE_MID_CRYSTAL  4'h1
`define OSC_CODE_HIGH_SPEED   4'h2
`define OSC_CODE_EXT_OUT      4'h4
`define OSC_CODE_EXT_GPIO     4'h5
`define OSC_CODE_RC_OUT       4'h3
`define OSC_CODE_RC_GPIO      4'h7
`define OSC_CODE_INT_GPIO     4'h8
`define OSC_CODE_INT_OUT      4'h9
// Reset value of the mode field register
`define OSC_MODE_RESET        4'h0

// ==========================================================
// Clock figures
`define PLL_FACTOR            4
`define CLKOUT_DIVIDE         4
`define PLL_MAX_OUT_MHZ       40
`define PLL_MAX_IN_MHZ        10
// Oscillator start-up delay in cycles for crystal and RC sources
`define OSC_START_CYCLES      16'h0400

// ==========================================================
// Register map (AXI4-Lite byte offsets)
`define REG_MODE_OFFSET       4'h0
`define REG_STATUS_OFFSET     4'h4
`define REG_PORT_A_REGISTER_OFFSET      4'h8
// Status register field positions
`define STAT_READY_BIT        0
`define STAT_PLL_BIT          1
`define STAT_OUT6_BIT         2
`define STAT_GPIO6_BIT        3
`define STAT_GPIO7_BIT        4
`define STAT_MODE_LSB         8
`define STAT_VALID_BIT        12

`endif

/* File: design/osc_mode_decoder.v */
// Decoder from the four-bit mode field to pin and clock roles.
// Assumes a registered mode field from the same clock domain.
`timescale 1ns/1ps
`include "osc_mode_consts.vh"
module osc_mode_decoder #(
  parameter [3:0] CODE_LOW_POWER = `OSC_CODE_LOW_POWER,
  parameter [3:0] CODE_MID       = `OSC_CODE_MID_CRYSTAL,
  parameter [3:0] CODE_HIGH      = `OSC_CODE_HIGH_SPEED,
  parameter [3:0] CODE_EXT_OUT   = `OSC_CODE_EXT_OUT,
  parameter [3:0] CODE_EXT_GPIO  = `OSC_CODE_EXT_GPIO,
  parameter [3:0] CODE_RC_OUT    = `OSC_CODE_RC_OUT,
  parameter [3:0] CODE_RC_GPIO   = `OSC_CODE_RC_GPIO,
  parameter [3:0] CODE_INT_OUT   = `OSC_CODE_INT_OUT,
  parameter [3:0] CODE_INT_GPIO  = `OSC_CODE_INT_GPIO
) (
  // Mode field
  input  wire [3:0] modeBits,
  // Decoded roles
  output reg  [2:0] sourceSel,
  output reg        pllEnable,
  output reg        line6ClockOut,
  output reg        line6Gpio,
  output reg        line7Gpio,
  output reg        needStartup,
  output reg        modeValid
);

  // Source selections: 0 crystal, 1 external, 2 RC, 3 internal
  localparam [2:0] SRC_CRYSTAL  = 3'h0;
  localparam [2:0] SRC_EXTERNAL = 3'h1;
  localparam [2:0] SRC_RC       = 3'h2;
  localparam [2:0] SRC_INTERNAL = 3'h3;

  // Role table, one branch per mode, one shared by the three non-PLL crystal modes
  always @* begin
    sourceSel     = SRC_CRYSTAL;
    pllEnable     = 1'b0;
    line6ClockOut = 1'b0;
    line6Gpio     = 1'b0;
    line7Gpio     = 1'b0;
    needStartup   = 1'b1;
    modeValid     = 1'b1;
    if (modeBits == `OSC_CODE_PLL_CRYSTAL) begin
      pllEnable = 1'b1;
    end else if (modeBits == CODE_LOW_POWER || modeBits == CODE_MID ||
                 modeBits == CODE_HIGH) begin
      sourceSel = SRC_CRYSTAL;
    end else if (modeBits == CODE_EXT_OUT) begin
      sourceSel     = SRC_EXTERNAL;
      line6ClockOut = 1'b1;
      needStartup   = 1'b0;
    end else if (modeBits == CODE_EXT_GPIO) begin
      sourceSel   = SRC_EXTERNAL;
      line6Gpio   = 1'b1;
      needStartup = 1'b0;
    end else if (modeBits == CODE_RC_OUT) begin
      sourceSel     = SRC_RC;
      line6ClockOut = 1'b1;
    end else if (modeBits == CODE_RC_GPIO) begin
      sourceSel = SRC_RC;
      line6Gpio = 1'b1;
    end else if (modeBits == CODE_INT_OUT) begin
      sourceSel     = SRC_INTERNAL;
      line6ClockOut = 1'b1;
      line7Gpio     = 1'b1;
      needStartup   = 1'b0;
    end else if (modeBits == CODE_INT_GPIO) begin
      sourceSel   = SRC_INTERNAL;
      line6Gpio   = 1'b1;
      line7Gpio   = 1'b1;
      needStartup = 1'b0;
    end else begin
      modeValid = 1'b0;                               // Unused codes fall back to crystal
    end
  end

endmodule

/* File: design/osc_pin_sync.v */
// Two-flip-flop synchroniser for pins entering the clk domain.
// Assumes the input is asynchronous; no logic reads the first stage.
`timescale 1ns/1ps
module osc_pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Data
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] stageOne;

  // Two stages, reset to zero
  always @(posedge clk) begin
    if (sys_rst) begin
      stageOne <= {WIDTH{1'b0}};
      pinSync  <= {WIDTH{1'b0}};
    end else begin
      stageOne <= pinIn;
      pinSync  <= stageOne;
    end
  end

endmodule

/* File: design/oscillator_mode_select.v */
// Oscillator mode selection: source choice, PLL gate, pin roles, start-up.
// Assumes clk is the system clock; pins pass two flip-flops on entry;
// software reaches the registers over AXI4-Lite.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "osc_mode_consts.vh"

// Functional notes
// - Ten oscillator modes chosen by the four-bit mode field.
// - Crystal modes keep both oscillator pins for the crystal, no GPIO.
// - High-speed crystal mode also accepts an external clock on input pin.
// - Internal mode one drives clock/4 on line 6; line 7 is GPIO.
// - Internal mode two frees lines 6 and 7 as GPIO.
// - External clock mode outputs input clock divided by four on output pin.
// - External clock GPIO mode makes output pin GPIO on port A bit 6.
// - External clock modes skip the start-up delay at reset and wake; the mode field resets to 0000 (crystal), so reset always starts the delay.
// - RC mode outputs oscillator frequency divided by four on output pin.
// - RC GPIO mode runs RC but makes output pin GPIO line 6.
// - PLL mode multiplies high-speed oscillator by four, at most 40 MHz.
// - PLL enabled only when the mode field holds 0110.
module oscillator_mode_select #(
  parameter [15:0] START_CYCLES = `OSC_START_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Wake from sleep request
  input  wire        wakeReq,
  // Oscillator input pin (external clock level, sampled)
  input  wire        oscInPin,
  // Port A line 6 (oscillator output pin) and line 7
  input  wire        line6In,
  output reg         line6Out,
  output reg         line6Oe,
  input  wire        line7In,
  output reg         line7Out,
  output reg         line7Oe,
  // Clock control outputs
  output reg         pllOn,
  output reg  [2:0]  clockSource,
  output reg         clockReady,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ==========================================================
  // Start-up states
  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_RUN  = 2'h1;
  localparam [1:0] RESP_OKAY   = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;

  reg  [3:0]  modeBits;
  reg  [1:0]  portAOut;
  reg  [1:0]  portADir;
  reg  [1:0]  startState;
  reg  [15:0] startCount;
  reg  [1:0]  divCount;
  reg         divClock;
  reg         oscPrev;
  reg         haveAw;
  reg         haveW;
  reg  [3:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  wire [2:0]  source;
  wire        pllWanted;
  wire        line6Clk;
  wire        line6Gpio;
  wire        line7Gpio;
  wire        needStart;
  wire        modeValid;
  wire [2:0]  pinSync;
  wire        oscSync;
  wire        line6Sync;
  wire        line7Sync;
  wire        oscRise;

  // ==========================================================
  // Pin synchronisers
  osc_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   ({oscInPin, line7In, line6In}),
    .pinSync (pinSync)
  );

  assign oscSync   = pinSync[2];
  assign line7Sync = pinSync[1];
  assign line6Sync = pinSync[0];

  // Mode field decoder
  osc_mode_decoder u_dec (
    .modeBits      (modeBits),
    .sourceSel     (source),
    .pllEnable     (pllWanted),
    .line6ClockOut (line6Clk),
    .line6Gpio     (line6Gpio),
    .line7Gpio     (line7Gpio),
    .needStartup   (needStart),
    .modeValid     (modeValid)
  );

  // ==========================================================
  // Start-up delay: crystal and RC wait, external and internal do not
  always @(posedge clk) begin
    if (sys_rst) begin
      startState <= ST_WAIT;
      startCount <= 16'h0000;
      clockReady <= 1'b0;
    end else begin
      case (startState)
        ST_WAIT: begin
          if (!needStart || startCount >= START_CYCLES - 16'h0001) begin
            startState <= ST_RUN;
            clockReady <= 1'b1;
            startCount <= 16'h0000;
          end else begin
            startCount <= startCount + 16'h0001;
          end
        end
        ST_RUN: begin
          if (wakeReq && needStart) begin
            startState <= ST_WAIT;                    // Wake restarts the delay
            clockReady <= 1'b0;
          end
        end
        default: begin
          startState <= ST_WAIT;
          clockReady <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Clock/4 source: external modes count input edges, others count clk
  assign oscRise = oscSync && !oscPrev;

  always @(posedge clk) begin
    if (sys_rst) begin
      oscPrev  <= 1'b0;
      divCount <= 2'h0;
      divClock <= 1'b0;
    end else begin
      oscPrev <= oscSync;
      if (source != 3'h1 || oscRise) begin
        divCount <= divCount + 2'h1;
        if (divCount == 2'h1 || divCount == 2'h3) begin
          divClock <= ~divClock;
        end
      end
    end
  end

  // ==========================================================
  // Pin roles and clock control outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      line6Out    <= 1'b0;
      line6Oe     <= 1'b0;
      line7Out    <= 1'b0;
      line7Oe     <= 1'b0;
      pllOn       <= 1'b0;
      clockSource <= 3'h0;
    end else begin
      pllOn       <= pllWanted;
      clockSource <= source;
      if (line6Clk) begin
        line6Out <= divClock;
        line6Oe  <= 1'b1;
      end else if (line6Gpio) begin
        line6Out <= portAOut[0];
        line6Oe  <= portADir[0];
      end else begin
        line6Out <= 1'b0;
        line6Oe  <= 1'b0;
      end
      line7Out <= line7Gpio & portAOut[1];
      line7Oe  <= line7Gpio & portADir[1];
    end
  end

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      modeBits      <= `OSC_MODE_RESET;
      portAOut      <= 2'h0;
      portADir      <= 2'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !haveAw && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        haveAw        <= 1'b1;
        awAddr        <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !haveW && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        haveW        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
      end
      if (haveAw && haveW && !s_axi_bvalid) begin
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (awAddr == `REG_MODE_OFFSET) begin
          if (wStrb[0]) modeBits <= wData[3:0];
        end else if (awAddr == `REG_PORT_A_REGISTER_OFFSET) begin
          if (wStrb[0]) begin
            portAOut <= wData[7:6];
          end
          if (wStrb[1]) begin
            portADir <= wData[15:14];
          end
        end else begin
          s_axi_bresp <= RESP_SLVERR;                 // Status is read-only; unmapped offsets answer SLVERR too
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr)
      `REG_MODE_OFFSET: next_rdata[3:0] = modeBits;
      `REG_STATUS_OFFSET: begin
        next_rdata[`STAT_READY_BIT] = clockReady;
        next_rdata[`STAT_PLL_BIT]   = pllOn;
        next_rdata[`STAT_OUT6_BIT]  = line6Clk;
        next_rdata[`STAT_GPIO6_BIT] = line6Gpio;
        next_rdata[`STAT_GPIO7_BIT] = line7Gpio;
        next_rdata[`STAT_MODE_LSB+2:`STAT_MODE_LSB] = source;
        next_rdata[`STAT_VALID_BIT] = modeValid;
      end
      `REG_PORT_A_REGISTER_OFFSET: begin
        next_rdata[6]     = line6Sync;
        next_rdata[7]     = line7Sync;
        next_rdata[15:14] = portADir;
      end
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  // AXI4-Lite read path
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: test/ext_clock_source.sv */
// Far-side clock source driving the oscillator input pin.
// Assumes the bench runs it only where a pin clock is wanted.
`timescale 1ns/1ps
module ext_clock_source #(
  parameter HALF_NS = 200
) (
  // Control
  input  wire run,
  // Pin
  output reg  oscInPin
);
  // ==========================================================
  // 2.5 MHz, under the PLL input limit and under clk/4; low when idle
  initial begin
    oscInPin = 1'b0;
    #13;
    forever begin
      #HALF_NS;
      if (run)
        oscInPin = ~oscInPin;
      else
        oscInPin = 1'b0;
    end
  end
endmodule

/* File: test/osc_mode_select_assertions.sv */
// Port checker for the oscillator mode selection block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module osc_mode_select_assertions #(
  parameter [15:0] START_CYCLES = 16'h0400
) (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Clock control and pins
  input wire        wakeReq,
  input wire        line6Oe,
  input wire        line7Oe,
  input wire        pllOn,
  input wire [2:0]  clockSource,
  input wire        clockReady,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_wvalid,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Cycles since reset or wake, saturating
  reg [15:0] quietCnt;
  always @(posedge clk) begin
    if (sys_rst || wakeReq)
      quietCnt <= 16'h0000;
    else if (quietCnt != 16'hFFFF)
      quietCnt <= quietCnt + 16'h0001;
  end
  // ==========================================================
  // Pin roles and clock gating
  AST_PLL_CRYSTAL: assert property (pllOn |-> clockSource == 3'h0 && !line6Oe)
    else $error("pll on outside crystal use");
  AST_CRYSTAL_PINS: assert property (clockSource == 3'h0 |-> !line6Oe && !line7Oe)
    else $error("crystal pin driven");
  AST_LINE7_INTERNAL: assert property (line7Oe |-> clockSource == 3'h3)
    else $error("line 7 driven outside internal modes");
  AST_EXT_READY: assert property ((clockSource == 3'h1) [*3] |-> clockReady)
    else $error("external clock not ready");
  AST_START_DELAY: assert property ($rose(clockReady) && (clockSource == 3'h0 ||
    clockSource == 3'h2) |-> quietCnt >= START_CYCLES - 16'h0001)
    else $error("start-up delay too short");
  // ==========================================================
  // Register bus answers
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
    ##[1:4] s_axi_bvalid)
    else $error("write not answered");
  AST_READ_ANSWER: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid)
    else $error("read not answered");
  // Main scenarios
  COV_PLL: cover property (pllOn);
  COV_READY: cover property ($rose(clockReady));
  COV_LINE7: cover property (line7Oe);
  COV_HELD_READ: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind oscillator_mode_select osc_mode_select_assertions #(.START_CYCLES(START_CYCLES)) chk (
  .clk(clk), .sys_rst(sys_rst), .wakeReq(wakeReq), .line6Oe(line6Oe), .line7Oe(line7Oe),
  .pllOn(pllOn), .clockSource(clockSource), .clockReady(clockReady),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: test/tb.sv */
// Self-checking bench for the oscillator mode selection block.
// Assumes the design, checker and clock source model are compiled first.
`timescale 1ns/1ps
module tb;
  localparam [15:0] START = 16'h0008;
  // ==========================================================
  // Bench signals
  reg         clk, sys_rst, wakeReq, extRun, farEn, far6, far7;
  reg  [3:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg         awvalid, wvalid, bready, arvalid, rready;
  wire        oscInPin, line6Out, line6Oe, line7Out, line7Oe, pllOn, clockReady;
  wire [2:0]  clockSource;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     mismatches, samples_checked;
  reg         respHold;  // Raise bready/rready only once the answer stands
  // Pin levels: design drive, else far side, else inverse of the design's output value
  wire line6In = line6Oe ? line6Out : (farEn ? far6 : ~line6Out);
  wire line7In = line7Oe ? line7Out : (farEn ? far7 : ~line7Out);

  oscillator_mode_select #(.START_CYCLES(START)) DUT (
    .clk(clk), .sys_rst(sys_rst), .wakeReq(wakeReq), .oscInPin(oscInPin),
    .line6In(line6In), .line6Out(line6Out), .line6Oe(line6Oe),
    .line7In(line7In), .line7Out(line7Out), .line7Oe(line7Oe),
    .pllOn(pllOn), .clockSource(clockSource), .clockReady(clockReady),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ext_clock_source src (.run(extRun), .oscInPin(oscInPin));

  // ==========================================================
  // Compare, bus and helper tasks
  task cmp32(input string what, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task axiWrite(input [3:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !respHold;
      @(posedge clk);
      while (bvalid !== 1'b1) begin
        if (awready === 1'b1)
          awvalid <= 1'b0;
        if (wready === 1'b1)
          wvalid <= 1'b0;
        @(posedge clk);
      end
      if (respHold) begin
        repeat (2) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
      end
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task axiRead(input [3:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !respHold;
      @(posedge clk);
      while (rvalid !== 1'b1) begin
        if (arready === 1'b1)
          arvalid <= 1'b0;
        @(posedge clk);
      end
      arvalid <= 1'b0;
      if (respHold) begin
        repeat (2) @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
  task setMode(input [3:0] m);
    reg [1:0] r;
    begin
      axiWrite(4'h0, {28'h0, m}, r);
      repeat (3) @(posedge clk);
    end
  endtask
  task countToggles(input integer n, output integer c);
    reg p;
    begin
      c = 0;
      p = line6Out;
      repeat (n) begin
        @(posedge clk);
        if (line6Out !== p)
          c = c + 1;
        p = line6Out;
      end
    end
  endtask
  task pulseWake;
    begin
      @(posedge clk);
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Expected status roles for a mode code, ready bit left out
  function [31:0] expStat(input [3:0] m);
    reg [2:0] s;
    reg       p, o6, g6, g7, v;
    begin
      {s, p, o6, g6, g7, v} = 8'h01;
      case (m)
        4'h3: {s, o6} = 4'h5;
        4'h4: {s, o6} = 4'h3;
        4'h5: {s, g6} = 4'h3;
        4'h6: p = 1'b1;
        4'h7: {s, g6} = 4'h5;
        4'h8: {s, g6, g7} = 5'h0F;
        4'h9: {s, o6, g7} = 5'h0F;
        4'h0, 4'h1, 4'h2: v = 1'b1;
        default: v = 1'b0;
      endcase
      expStat = {19'h0, v, 1'b0, s, 3'h0, g7, g6, o6, p, 1'b0};
    end
  endfunction

  // ==========================================================
  // Scenarios
  task testReset;
    reg [31:0] d;
    reg [1:0]  r;
    begin
      cmp32("clockReady at release", 32'h0, {31'h0, clockReady});
      axiRead(4'h0, d, r);
      cmp32("mode reset", 32'h0, d);
      repeat (START + 4) @(posedge clk);
      axiRead(4'h4, d, r);
      cmp32("status after start", 32'h00001001, d);
      axiRead(4'h8, d, r);
      cmp32("port a reset", 32'h0, d & 32'h0000C0C0);
      $display("test reset done");
    end
  endtask
  task testModes;
    reg [31:0] d, e;
    reg [1:0]  r;
    integer    m;
    begin
      for (m = 0; m < 11; m = m + 1) begin
        setMode(m[3:0]);
        e = expStat(m[3:0]);
        axiRead(4'h4, d, r);
        cmp32("status roles", e, d & 32'h00001FFE);
        cmp32("pllOn pin", {31'h0, m == 6}, {31'h0, pllOn});
        cmp32("clockSource pin", {29'h0, e[10:8]}, {29'h0, clockSource});
      end
      $display("test modes done");
    end
  endtask
  task testClockOut;
    integer c;
    begin
      setMode(4'h9);
      countToggles(32, c);
      cmp32("internal clock out toggles", 16, c);
      setMode(4'h3);
      countToggles(32, c);
      cmp32("rc clock out toggles", 16, c);
      extRun = 1'b1;
      setMode(4'h4);
      countToggles(256, c);
      cmp32("ext clock out near 16", 1, c >= 15 && c <= 17);
      cmp32("ext clock out drive", 1, {31'h0, line6Oe});
      $display("test clock out done");
    end
  endtask
  task testGpio;
    reg [31:0] d;
    reg [1:0]  r;
    integer    c;
    begin
      setMode(4'h8);
      axiWrite(4'h8, 32'h0000C080, r);
      repeat (2) @(posedge clk);
      cmp32("internal gpio pins", 32'hE, {line7Oe, line7Out, line6Oe, line6Out});
      far6 <= 1'b1;
      axiWrite(4'h8, 32'h0, r);
      repeat (4) @(posedge clk);
      axiRead(4'h8, d, r);
      cmp32("port a inputs", 32'h40, d & 32'h0000C0C0);
      setMode(4'h5);
      axiWrite(4'h8, 32'h00004040, r);
      repeat (2) @(posedge clk);
      cmp32("ext gpio pins", 32'h3, {line7Oe, line6Oe, line6Out});
      countToggles(64, c);
      cmp32("ext gpio no clock", 0, c);
      setMode(4'h2);
      axiWrite(4'h8, 32'h0000C0C0, r);
      repeat (2) @(posedge clk);
      cmp32("crystal pins free", 32'h0, {line7Oe, line6Oe});
      extRun = 1'b0;
      $display("test gpio done");
    end
  endtask
  task testWake;
    begin
      repeat (START + 4) @(posedge clk);
      pulseWake;
      cmp32("ready after crystal wake", 0, {31'h0, clockReady});
      repeat (START + 4) @(posedge clk);
      cmp32("ready after start-up", 1, {31'h0, clockReady});
      setMode(4'h4);
      pulseWake;
      cmp32("ready after external wake", 1, {31'h0, clockReady});
      $display("test wake done");
    end
  endtask
  task testErrors;
    reg [31:0] d;
    reg [1:0]  r;
    begin
      respHold = 1'b1;
      axiRead(4'hC, d, r);
      cmp32("unmapped read resp", 2, r);
      cmp32("unmapped read data", 0, d);
      axiWrite(4'h4, 32'hFFFFFFFF, r);
      cmp32("status write resp", 2, r);
      axiWrite(4'hC, 32'h0, r);
      cmp32("unmapped write resp", 2, r);
      respHold = 1'b0;
      $display("test errors done");
    end
  endtask

  // ==========================================================
  // Clock, sequence, watchdog and verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    mismatches = 0;
    samples_checked = 0;
    {sys_rst, wakeReq, extRun, farEn, far6, far7} = 6'h24;
    {awaddr, araddr, wdata} = 40'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    respHold = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    testReset;
    testModes;
    testClockOut;
    testGpio;
    testWake;
    testErrors;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    $display("watchdog expired");
    summarize;
  end
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
endmodule
